//--- rtl/lcr_cfg.svh
`ifndef LCR_CFG_SVH
`define LCR_CFG_SVH
// ************************************************************
// Register offsets
// ************************************************************
`define LCR_OFS_EQ      8'h2C
`define LCR_OFS_SWA     8'h2D
`define LCR_OFS_DEMA    8'h2E
`define LCR_OFS_IDLTH   8'h2F
`define LCR_OFS_IRSEL   8'h32
`define LCR_OFS_SWB     8'h34
// ************************************************************
// Reset values
// ************************************************************
`define LCR_RST_EQ      8'h20
`define LCR_RST_SWA     8'h03
`define LCR_RST_DEMA    8'h03
`define LCR_RST_IDLTH   8'h00
`define LCR_RST_IRSEL   8'h00
`define LCR_RST_SWB     8'h03
// ************************************************************
// Field positions and writable masks
// ************************************************************
`define LCR_EQ_EN_BIT   5
`define LCR_DEM_TYPE_BIT 7
`define LCR_IDLE_AUTO_BIT 5
`define LCR_IDLE_FORCE_BIT 4
`define LCR_RATE_AUTO_BIT 1
`define LCR_RATE_FORCE_BIT 0
`define LCR_MSK_EQ      8'h3F
`define LCR_MSK_SW      8'h7F
`define LCR_MSK_DEM     8'hFF
`define LCR_MSK_IDLTH   8'h0F
`define LCR_MSK_IRSEL   8'h33
// ************************************************************
// Decoded codes
// ************************************************************
`define LCR_EQ_BYPASS   6'h20
`define LCR_SW_600      7'h03
`define LCR_SW_800      7'h07
`define LCR_SW_1000     7'h0F
`define LCR_SW_1200     7'h1F
`define LCR_SW_RSVD     7'h3F
`define LCR_DEM_0DB     8'h01
`define LCR_DEM_3P5     8'hE8
`define LCR_DEM_6P0     8'h88
`define LCR_DEM_9P0     8'h90
`define LCR_DEM_12P0    8'hA0
`endif

//--- rtl/lcr_pkg.sv
`default_nettype none
package lcr_pkg;
    // Equalizer strength: bypass, then eight boost steps, then unsupported
    typedef enum logic [3:0] {
        LCR_EQ_BYP, LCR_EQ_5DB, LCR_EQ_9DB, LCR_EQ_11P7DB, LCR_EQ_14P6DB,
        LCR_EQ_18P4DB, LCR_EQ_20DB, LCR_EQ_21P2DB, LCR_EQ_28P4DB, LCR_EQ_BAD
    } lcr_eq_t;
    typedef enum logic [2:0] {
        LCR_SW_600MV, LCR_SW_800MV, LCR_SW_1000MV, LCR_SW_1200MV, LCR_SW_RESV, LCR_SW_BAD
    } lcr_sw_t;
    typedef enum logic [2:0] {
        LCR_DE_0DB, LCR_DE_M3P5DB, LCR_DE_M6DB, LCR_DE_M9DB, LCR_DE_M12DB, LCR_DE_BAD
    } lcr_de_t;
endpackage
`default_nettype wire

//--- rtl/lcr_regs.sv
// How it works
// - Equalizer field: enable bit 5, gain stage bits 4:3, boost bits 2:0.
// - Equalizer code 20 hex means bypass and is the reset default.
// - Codes 2A,30,32,39,35,37,3B,3D decode as rising boost, 5 to 28.4 dB.
// - Swing codes 03,07,0F,1F give 600 to 1200 mV; 03 default; 3F reserved.
// - De-emphasis bit 7 picks compatibility (0) or enhanced (1) type.
// - De-emphasis 01,E8,88,90,A0 decode as 0,-3.5,-6,-9,-12 dB.
// - Idle threshold: de-assert select bits 3:2, assert select bits 1:0.
// - Threshold codes 00..11 map 110/70, 150/110, 170/130, 190/150 mV.
// - Idle auto bit 5 set means automatic idle; else force bit 4 rules.
// - Manual idle: force 0 keeps output on, detect off; 1 mutes output.
// - Rate auto bit 1 set means automatic rate; else force bit 0 rules.
`include "lcr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lcr_regs
    import lcr_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // Management access
    input  wire logic       WR_EN,
    input  wire logic       RD_EN,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WR_DATA,
    output logic      [7:0] RD_DATA,
    output logic            RD_HIT,
    // Equalizer controls
    output logic            EQ_ENABLE,
    output logic      [1:0] GAIN_STAGE_SELECTOR,
    output logic      [2:0] BOOST_LEVEL_SELECTOR,
    output lcr_eq_t         EQ_STRENGTH,
    // Idle thresholds
    output logic      [1:0] IDLE_DEASSERT_SEL,
    output logic      [1:0] IDLE_ASSERT_SEL,
    output logic      [7:0] IDLE_DEASSERT_MV,
    output logic      [7:0] IDLE_ASSERT_MV,
    // Output port a zero drive
    output lcr_sw_t         OUTPUT_SWING_A,
    output logic            DEEMPHASIS_ENHANCED_A,
    output lcr_de_t         DEEMPHASIS_SETTING_A,
    // Output port b zero drive and idle/rate
    output lcr_sw_t         OUTPUT_SWING_B,
    output logic            IDLE_AUTO_B,
    output logic            OUTPUT_MUTE_B,
    output logic            SIGNAL_DETECT_EN_B,
    output logic            RATE_AUTO_B,
    output logic            RATE_HIGH_B
);
    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] eq_q, eq_d, swa_q, swa_d, dema_q, dema_d;
    logic [7:0] idl_q, idl_d, irs_q, irs_d, swb_q, swb_d;
    logic [7:0] rd_q, rd_d;
    logic       hit_q, hit_d;

    function automatic lcr_sw_t sw_decode(input logic [6:0] c);
        case (c)
            `LCR_SW_600:  sw_decode = LCR_SW_600MV;
            `LCR_SW_800:  sw_decode = LCR_SW_800MV;
            `LCR_SW_1000: sw_decode = LCR_SW_1000MV;
            `LCR_SW_1200: sw_decode = LCR_SW_1200MV;
            `LCR_SW_RSVD: sw_decode = LCR_SW_RESV;
            default:      sw_decode = LCR_SW_BAD;
        endcase
    endfunction

    function automatic logic [7:0] th_mv(input logic [1:0] c, input logic deassert);
        case (c)
            2'h0:    th_mv = deassert ? 8'h6E : 8'h46;
            2'h1:    th_mv = deassert ? 8'h96 : 8'h6E;
            2'h2:    th_mv = deassert ? 8'hAA : 8'h82;
            default: th_mv = deassert ? 8'hBE : 8'h96;
        endcase
    endfunction

    // Reserved bits are masked on write so readback always shows zero there
    always_comb begin
        eq_d   = eq_q;
        swa_d  = swa_q;
        dema_d = dema_q;
        idl_d  = idl_q;
        irs_d  = irs_q;
        swb_d  = swb_q;
        if (WR_EN) begin
            case (ADDR)
                `LCR_OFS_EQ:    eq_d   = WR_DATA & `LCR_MSK_EQ;
                `LCR_OFS_SWA:   swa_d  = WR_DATA & `LCR_MSK_SW;
                `LCR_OFS_DEMA:  dema_d = WR_DATA & `LCR_MSK_DEM;
                `LCR_OFS_IDLTH: idl_d  = WR_DATA & `LCR_MSK_IDLTH;
                `LCR_OFS_IRSEL: irs_d  = WR_DATA & `LCR_MSK_IRSEL;
                `LCR_OFS_SWB:   swb_d  = WR_DATA & `LCR_MSK_SW;
                default: begin
                end
            endcase
        end
        rd_d  = 8'h00;
        hit_d = 1'b1;
        case (ADDR)
            `LCR_OFS_EQ:    rd_d = eq_q;
            `LCR_OFS_SWA:   rd_d = swa_q;
            `LCR_OFS_DEMA:  rd_d = dema_q;
            `LCR_OFS_IDLTH: rd_d = idl_q;
            `LCR_OFS_IRSEL: rd_d = irs_q;
            `LCR_OFS_SWB:   rd_d = swb_q;
            default:        hit_d = 1'b0;
        endcase
        if (!RD_EN) begin
            rd_d  = rd_q;
            hit_d = hit_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            eq_q   <= `LCR_RST_EQ;
            swa_q  <= `LCR_RST_SWA;
            dema_q <= `LCR_RST_DEMA;
            idl_q  <= `LCR_RST_IDLTH;
            irs_q  <= `LCR_RST_IRSEL;
            swb_q  <= `LCR_RST_SWB;
            rd_q   <= 8'h00;
            hit_q  <= 1'b0;
        end else begin
            eq_q   <= eq_d;
            swa_q  <= swa_d;
            dema_q <= dema_d;
            idl_q  <= idl_d;
            irs_q  <= irs_d;
            swb_q  <= swb_d;
            rd_q   <= rd_d;
            hit_q  <= hit_d;
        end
    end

    // ************************************************************
    // Field decode
    // ************************************************************
    assign RD_DATA              = rd_q;
    assign RD_HIT               = hit_q;
    assign EQ_ENABLE            = eq_q[`LCR_EQ_EN_BIT];
    assign GAIN_STAGE_SELECTOR  = eq_q[4:3];
    assign BOOST_LEVEL_SELECTOR = eq_q[2:0];

    always_comb begin
        case (eq_q[5:0])
            `LCR_EQ_BYPASS: EQ_STRENGTH = LCR_EQ_BYP;
            6'h2A:          EQ_STRENGTH = LCR_EQ_5DB;
            6'h30:          EQ_STRENGTH = LCR_EQ_9DB;
            6'h32:          EQ_STRENGTH = LCR_EQ_11P7DB;
            6'h39:          EQ_STRENGTH = LCR_EQ_14P6DB;
            6'h35:          EQ_STRENGTH = LCR_EQ_18P4DB;
            6'h37:          EQ_STRENGTH = LCR_EQ_20DB;
            6'h3B:          EQ_STRENGTH = LCR_EQ_21P2DB;
            6'h3D:          EQ_STRENGTH = LCR_EQ_28P4DB;
            default:        EQ_STRENGTH = LCR_EQ_BAD;
        endcase
        case (dema_q)
            `LCR_DEM_0DB:  DEEMPHASIS_SETTING_A = LCR_DE_0DB;
            `LCR_DEM_3P5:  DEEMPHASIS_SETTING_A = LCR_DE_M3P5DB;
            `LCR_DEM_6P0:  DEEMPHASIS_SETTING_A = LCR_DE_M6DB;
            `LCR_DEM_9P0:  DEEMPHASIS_SETTING_A = LCR_DE_M9DB;
            `LCR_DEM_12P0: DEEMPHASIS_SETTING_A = LCR_DE_M12DB;
            default:       DEEMPHASIS_SETTING_A = LCR_DE_BAD;
        endcase
    end

    assign IDLE_DEASSERT_SEL     = idl_q[3:2];
    assign IDLE_ASSERT_SEL       = idl_q[1:0];
    assign IDLE_DEASSERT_MV      = th_mv(idl_q[3:2], 1'b1);
    assign IDLE_ASSERT_MV        = th_mv(idl_q[1:0], 1'b0);
    assign OUTPUT_SWING_A        = sw_decode(swa_q[6:0]);
    assign OUTPUT_SWING_B        = sw_decode(swb_q[6:0]);
    assign DEEMPHASIS_ENHANCED_A = dema_q[`LCR_DEM_TYPE_BIT];
    // In automatic mode the analogue detector owns muting; force bit is ignored
    assign IDLE_AUTO_B           = irs_q[`LCR_IDLE_AUTO_BIT];
    assign OUTPUT_MUTE_B         = !IDLE_AUTO_B && irs_q[`LCR_IDLE_FORCE_BIT];
    assign SIGNAL_DETECT_EN_B    = IDLE_AUTO_B;
    assign RATE_AUTO_B           = irs_q[`LCR_RATE_AUTO_BIT];
    assign RATE_HIGH_B           = !RATE_AUTO_B && irs_q[`LCR_RATE_FORCE_BIT];

    // ************************************************************
    // Checks
    // ************************************************************
    a_eq_default: assert property (@(posedge CLK) SYS_RST |=> eq_q == `LCR_RST_EQ)
        else $error("equalizer default wrong");
    // Host strobes leave one idle edge between them, so the read lands two edges after the write
    a_write_readback: assert property (@(posedge CLK) disable iff (SYS_RST)
        (WR_EN && ADDR == `LCR_OFS_SWA) ##1 !WR_EN ##1 (RD_EN && ADDR == `LCR_OFS_SWA && !WR_EN)
        |=> RD_DATA == ($past(WR_DATA, 3) & `LCR_MSK_SW))
        else $error("swing readback wrong");
    a_rsvd_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
        (irs_q & 8'hCC) == 8'h00 && (idl_q & 8'hF0) == 8'h00 && (eq_q & 8'hC0) == 8'h00
        && !swa_q[7] && !swb_q[7])
        else $error("reserved bits nonzero");
    a_mute_manual: assert property (@(posedge CLK) disable iff (SYS_RST)
        !irs_q[`LCR_IDLE_AUTO_BIT] |-> OUTPUT_MUTE_B == irs_q[`LCR_IDLE_FORCE_BIT] && !SIGNAL_DETECT_EN_B)
        else $error("mute without manual force");
    a_rate_manual: assert property (@(posedge CLK) disable iff (SYS_RST)
        (WR_EN && ADDR == `LCR_OFS_IRSEL && !WR_DATA[`LCR_RATE_AUTO_BIT])
        |=> RATE_HIGH_B == $past(WR_DATA[`LCR_RATE_FORCE_BIT]))
        else $error("manual rate wrong");
    a_eq_decode: assert property (@(posedge CLK) disable iff (SYS_RST)
        eq_q[5:0] == 6'h3D |-> EQ_STRENGTH == LCR_EQ_28P4DB && BOOST_LEVEL_SELECTOR == 3'h5)
        else $error("equalizer decode wrong");
    a_dem_decode: assert property (@(posedge CLK) disable iff (SYS_RST)
        dema_q == 8'hE8 |-> DEEMPHASIS_SETTING_A == LCR_DE_M3P5DB && DEEMPHASIS_ENHANCED_A)
        else $error("de-emphasis decode wrong");
    a_swing_decode: assert property (@(posedge CLK) disable iff (SYS_RST)
        swb_q == 8'h1F |-> OUTPUT_SWING_B == LCR_SW_1200MV)
        else $error("swing decode wrong");
    a_thresh_map: assert property (@(posedge CLK) disable iff (SYS_RST)
        idl_q[3:2] == 2'h3 |-> IDLE_DEASSERT_MV == 8'hBE)
        else $error("threshold map wrong");
endmodule
`default_nettype wire

//--- tb/lcr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Host side of the management access
// ********
module lcr_host (
    // Clock
    input  wire logic       clk,
    // Access strobes
    output logic            wr_en,
    output logic            rd_en,
    output logic      [7:0] addr,
    output logic      [7:0] wr_data,
    // Read return
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_hit
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
    end
    // Reserved bits are left to the caller, which passes zeros there
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        wr_en = 1'b1;
        addr = a;
        wr_data = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        // Released lines flip so a stale value is never mistaken for a live one
        addr = ~a;
        wr_data = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge clk);
        #1;
        rd_en = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        d = rd_data;
        h = rd_hit;
        rd_en = 1'b0;
        addr = ~a;
    endtask
endmodule
`default_nettype wire

//--- tb/lcr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((e) !== (a)) begin fail_count++; \
    $display("BAD %s exp %0h got %0h", n, e, a); end end
module lcr_regs_tb import lcr_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, wr_en, rd_en, rd_hit, eq_en, dea, iab, mute, sde, rab, rhb;
    logic [7:0] addr, wr_data, rd_data, idmv, iamv;
    logic [1:0] gain_stage_selector, ides, iass;
    logic [2:0] boost_level_selector;
    lcr_eq_t    eq_s;
    lcr_sw_t    swa, swb;
    lcr_de_t    dsa;
    int         fail_count = 0, checks_done = 0;
    logic [7:0] ofs [6] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h32, 8'h34};
    logic [7:0] rv  [6] = '{8'h20, 8'h03, 8'h03, 8'h00, 8'h00, 8'h03};
    logic [7:0] msk [6] = '{8'h3F, 8'h7F, 8'hFF, 8'h0F, 8'h33, 8'h7F};
    always #50 clk = ~clk;
    lcr_host host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
        .rd_data(rd_data), .rd_hit(rd_hit));
    lcr_regs dut (.CLK(clk), .SYS_RST(rst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
        .WR_DATA(wr_data), .RD_DATA(rd_data), .RD_HIT(rd_hit), .EQ_ENABLE(eq_en),
        .GAIN_STAGE_SELECTOR(gain_stage_selector), .BOOST_LEVEL_SELECTOR(boost_level_selector), .EQ_STRENGTH(eq_s),
        .IDLE_DEASSERT_SEL(ides), .IDLE_ASSERT_SEL(iass), .IDLE_DEASSERT_MV(idmv),
        .IDLE_ASSERT_MV(iamv), .OUTPUT_SWING_A(swa), .DEEMPHASIS_ENHANCED_A(dea),
        .DEEMPHASIS_SETTING_A(dsa), .OUTPUT_SWING_B(swb), .IDLE_AUTO_B(iab),
        .OUTPUT_MUTE_B(mute), .SIGNAL_DETECT_EN_B(sde), .RATE_AUTO_B(rab), .RATE_HIGH_B(rhb));
    // ********
    // Scenarios
    // ********
    task automatic t_defaults();
        logic [7:0] d;
        logic h;
        foreach (ofs[i]) begin
            host.rd(ofs[i], d, h);
            `CHK("reset value", rv[i], d)
            `CHK("read hit", 1'b1, h)
        end
        `CHK("eq bypass", LCR_EQ_BYP, eq_s)
        `CHK("deemph default", LCR_DE_BAD, dsa)
        `CHK("swing a", LCR_SW_600MV, swa)
        `CHK("swing b", LCR_SW_600MV, swb)
        `CHK("deassert mv", 8'(110), idmv)
        `CHK("assert mv", 8'(70), iamv)
    endtask
    task automatic t_eq();
        logic [7:0] c [9] = '{8'h20, 8'h2A, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37, 8'h3B, 8'h3D};
        foreach (c[i]) begin
            host.wr(8'h2C, c[i]);
            `CHK("eq strength", lcr_eq_t'(i), eq_s)
            `CHK("eq fields", c[i][5:0], {eq_en, gain_stage_selector, boost_level_selector})
        end
    endtask
    task automatic t_drive();
        logic [7:0] s [5] = '{8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F};
        logic [7:0] e [5] = '{8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0};
        foreach (s[i]) begin
            host.wr(8'h2D, s[i]);
            host.wr(8'h34, s[4 - i]);
            host.wr(8'h2E, e[i]);
            `CHK("swing a", lcr_sw_t'(i), swa)
            `CHK("swing b", lcr_sw_t'(4 - i), swb)
            `CHK("deemph level", lcr_de_t'(i), dsa)
            `CHK("deemph type", e[i][7], dea)
        end
    endtask
    task automatic t_idle_rate();
        logic [7:0] dmv [4] = '{8'(110), 8'(150), 8'(170), 8'(190)};
        logic [7:0] amv [4] = '{8'(70), 8'(110), 8'(130), 8'(150)};
        logic [3:0] k;
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            host.wr(8'h2F, {4'h0, k});
            host.wr(8'h32, {2'b00, k[3:2], 2'b00, k[1:0]});
            `CHK("idle sel", k, {ides, iass})
            `CHK("deassert mv", dmv[k[3:2]], idmv)
            `CHK("assert mv", amv[k[1:0]], iamv)
            `CHK("idle auto", {k[3], k[3]}, {iab, sde})
            `CHK("mute", ~k[3] & k[2], mute)
            `CHK("rate auto", k[1], rab)
            `CHK("rate high", ~k[1] & k[0], rhb)
        end
    endtask
    task automatic t_reserved();
        logic [7:0] d;
        logic h;
        // Every writable bit set, reserved bits kept zero as the host must
        foreach (ofs[i]) begin
            host.wr(ofs[i], msk[i]);
            host.rd(ofs[i], d, h);
            `CHK("masked readback", msk[i], d)
        end
        `CHK("eq unsupported", LCR_EQ_BAD, eq_s)
        `CHK("swing a unsupported", LCR_SW_BAD, swa)
        `CHK("deemph unsupported", LCR_DE_BAD, dsa)
        host.wr(8'h30, 8'hAA);
        host.rd(8'h30, d, h);
        `CHK("unmapped data", 8'h00, d)
        `CHK("unmapped hit", 1'b0, h)
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        t_defaults();
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        t_defaults();
        t_eq();
        t_drive();
        t_idle_rate();
        t_reserved();
        conclude();
    end
    // Run needs under two hundred cycles; give it 5000, over twenty-five times that
    initial begin
        #(5000 * 100);
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
